// *** verilog/tsp_sensor_port.sv ***
// Two-wire register port of the temperature sensor with its register file
//
// Overview of operation
// - Eight-bit index, low two bits select register
// - Codes: temperature, config, low, high limit
// - Reset clears the select bits to zero
// - Result register holds last conversion, 1 C/count
// - Rate bits give 0.25, 1, 4, 8 per second
// - Conversion takes 26 ms, result then readable
// - Bus timeout about 30 ms, below 40 ms
// - Answer one fixed address in 1110xxx range
// - Addressed transfers read each register and write all but temperature
// - Obey global commands reaching all sensors at once
// - Mode 00 finishes conversion then shuts down
// - One-shot: mode reads 01 then returns 00
// - Set high or low flag after conversion
// - Config read clears flags; unlatched also clear
`timescale 1ns/1ps
`default_nettype none
module tsp_sensor_port import tsp_pkg::*; #(
    parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF,
    parameter logic [6:0] GLOBAL_ADDR = GLOBAL_ADDR_DEF,
    parameter int unsigned CONV_CYCLES = CONV_CYC,
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned PERIOD_0 = PERIOD_CYC_0,
    parameter int unsigned PERIOD_1 = PERIOD_CYC_1,
    parameter int unsigned PERIOD_2 = PERIOD_CYC_2,
    parameter int unsigned PERIOD_3 = PERIOD_CYC_3
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [7:0] temp_sample_in,
    output logic sda_data_out,
    output logic sda_oe_out,
    output logic conv_busy_out
);
    // Refuse settings the logic cannot serve
    if (OWN_ADDR[6:3] != ADDR_FAMILY) begin : g_bad_addr
        $error("own address outside sensor family");
    end
    if (CONV_CYCLES < 1 || TIMEOUT_CYCLES < 2 || PERIOD_3 <= CONV_CYCLES ||
        PERIOD_2 <= CONV_CYCLES || PERIOD_1 <= CONV_CYCLES ||
        PERIOD_0 <= CONV_CYCLES) begin : g_bad_time
        $error("conversion period shorter than conversion");
    end

    logic [2:0] scl_sync_q, sda_sync_q;
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_now;
    tsp_bus_st_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, idx_q, idx_d, temp_q, temp_d;
    logic [7:0] lo_q, lo_d, hi_q, hi_d, sel_reg;
    tsp_cfg_t cfg_q, cfg_d;
    logic oe_q, oe_d, first_q, first_d, rd_q, rd_d, nack_q, nack_d;
    logic hit_global_q, hit_global_d;
    logic [31:0] to_q, to_d;
    tsp_conv_t conv;
    logic over, under;

    // Two-stage synchronisers plus one stage for edge detection
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], scl_in};
            sda_sync_q <= {sda_sync_q[1:0], sda_in};
        end
    end

    // Bus conditions seen on the synchronised lines
    assign sda_now = sda_sync_q[1];
    assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
    assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
    assign bus_start = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[2] & ~sda_now;
    assign bus_stop = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[2] & sda_now;

    // Register chosen by the select bits for reads
    always_comb begin
        unique case (idx_q[1:0])
            SEL_TEMP: sel_reg = temp_q;
            SEL_CFG: sel_reg = cfg_q;
            SEL_LOW: sel_reg = lo_q;
            SEL_HIGH: sel_reg = hi_q;
        endcase
    end

    // Limit comparison on the fresh result, two's complement
    assign over = $signed(conv.value) > $signed(hi_q);
    assign under = $signed(conv.value) < $signed(lo_q);

    // Next state of the serial engine and the register file
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        oe_d = oe_q;
        idx_d = idx_q;
        cfg_d = cfg_q;
        lo_d = lo_q;
        hi_d = hi_q;
        temp_d = temp_q;
        first_d = first_q;
        rd_d = rd_q;
        nack_d = nack_q;
        hit_global_d = hit_global_q;
        to_d = (st_q == BS_IDLE || scl_rise || scl_fall) ? 32'h0 : to_q + 32'h1;
        if (bus_start) begin
            st_d = BS_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (bus_stop) begin
            st_d = BS_IDLE;
            oe_d = 1'b0;
        end else if (st_q != BS_IDLE && to_q >= 32'(TIMEOUT_CYCLES - 1)) begin
            st_d = BS_IDLE;
            oe_d = 1'b0;
        end else begin
            unique case (st_q)
                BS_IDLE: ;
                BS_ADDR, BS_WR: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_now};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        if (st_q == BS_WR) begin
                            st_d = BS_ACK_W;
                            oe_d = 1'b1;
                            first_d = 1'b0;
                            if (first_q) begin
                                idx_d = sh_q;
                            end else begin
                                unique case (idx_q[1:0])
                                    SEL_TEMP: ;
                                    SEL_CFG: begin
                                        cfg_d.rate = sh_q[6:5];
                                        cfg_d.flag_latch_enable = sh_q[2];
                                        cfg_d.mode = sh_q[1:0];
                                    end
                                    SEL_LOW: lo_d = sh_q;
                                    SEL_HIGH: hi_d = sh_q;
                                endcase
                            end
                        end else if (sh_q[7:1] == OWN_ADDR ||
                                     sh_q[7:1] == GLOBAL_ADDR) begin
                            st_d = BS_ACK_A;
                            oe_d = 1'b1;
                            rd_d = sh_q[0];
                            first_d = 1'b1;
                            hit_global_d = sh_q[7:1] == GLOBAL_ADDR;
                        end else begin
                            st_d = BS_IDLE;
                        end
                    end
                end
                BS_ACK_W: begin
                    if (scl_fall) begin
                        st_d = BS_WR;
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                    end
                end
                BS_RD: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        st_d = BS_MACK;
                        oe_d = 1'b0;
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
                BS_ACK_A, BS_MACK: begin
                    if (scl_rise) begin
                        nack_d = sda_now;
                    end else if (scl_fall && st_q == BS_ACK_A && !rd_q) begin
                        st_d = BS_WR;
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                    end else if (scl_fall && st_q == BS_MACK && nack_q) begin
                        st_d = BS_IDLE;
                    end else if (scl_fall) begin
                        st_d = BS_RD;
                        cnt_d = 4'h0;
                        sh_d = sel_reg;
                        oe_d = ~sel_reg[7];
                        if (idx_q[1:0] == SEL_CFG) begin
                            cfg_d.over_limit_flag = 1'b0;
                            cfg_d.under_limit_flag = 1'b0;
                        end
                    end
                end
                default: st_d = BS_IDLE;
            endcase
        end
        // Conversion results land last so a flag set beats any clear
        if (conv.done) begin
            temp_d = conv.value;
            cfg_d.over_limit_flag = over |
                (cfg_q.flag_latch_enable & cfg_d.over_limit_flag);
            cfg_d.under_limit_flag = under |
                (cfg_q.flag_latch_enable & cfg_d.under_limit_flag);
            if (cfg_q.mode == MODE_ONE) begin
                cfg_d.mode = MODE_SHUT;
            end
        end
    end

    // Serial engine and register file state
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q <= BS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            oe_q <= 1'b0;
            idx_q <= IDX_RESET;
            cfg_q <= tsp_cfg_t'(CFG_RESET);
            lo_q <= LOW_RESET;
            hi_q <= HIGH_RESET;
            temp_q <= TEMP_RESET;
            first_q <= 1'b0;
            rd_q <= 1'b0;
            nack_q <= 1'b0;
            hit_global_q <= 1'b0;
            to_q <= 32'h0;
            sda_data_out <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            oe_q <= oe_d;
            idx_q <= idx_d;
            cfg_q <= cfg_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
            temp_q <= temp_d;
            first_q <= first_d;
            rd_q <= rd_d;
            nack_q <= nack_d;
            hit_global_q <= hit_global_d;
            to_q <= to_d;
            sda_data_out <= 1'b0;
        end
    end

    assign sda_oe_out = oe_q;

    // Conversion timing
    tsp_conv_sched #(
        .CONV_CYCLES(CONV_CYCLES),
        .PERIOD_0(PERIOD_0),
        .PERIOD_1(PERIOD_1),
        .PERIOD_2(PERIOD_2),
        .PERIOD_3(PERIOD_3)
    ) u_sched (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .mode_in(cfg_q.mode),
        .rate_in(cfg_q.rate),
        .sample_in(temp_sample_in),
        .conv_out(conv),
        .busy_out(conv_busy_out)
    );

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_idx_reset: assert property ($rose(rst_b_in) |-> idx_q == 8'h00)
        else $error("index not cleared by reset");
    a_temp_source: assert property (temp_q != $past(temp_q) |->
        $past(conv.done) && temp_q == $past(conv.value))
        else $error("result changed without conversion");
    a_oneshot_end: assert property (conv.done && cfg_q.mode == 2'h1
        |=> cfg_q.mode == 2'h0) else $error("one-shot mode not cleared");
    a_high_flag: assert property (conv.done && over
        |=> cfg_q.over_limit_flag) else $error("high flag not set");
    a_flag_follow: assert property (conv.done && !cfg_q.flag_latch_enable
        && !over && !under |=> !cfg_q.over_limit_flag && !cfg_q.under_limit_flag)
        else $error("unlatched flags not cleared");
    a_bus_timeout: assert property (st_q != BS_IDLE && !bus_start &&
        to_q == 32'(TIMEOUT_CYCLES - 1) |=> st_q == BS_IDLE && !sda_oe_out)
        else $error("stalled bus not released");
    a_addr_match: assert property (st_q == BS_ADDR && st_d == BS_ACK_A |->
        sh_q[7:1] == OWN_ADDR || sh_q[7:1] == GLOBAL_ADDR)
        else $error("acknowledged foreign address");
    a_read_select: assert property (st_q != BS_RD ##1 st_q == BS_RD |->
        sh_q == $past(sel_reg) && sda_oe_out == !sh_q[7])
        else $error("read byte not from selected register");
    c_global_hit: cover property (st_q == BS_ACK_A && hit_global_q);
    c_timeout: cover property (st_q != BS_IDLE ##1 st_q == BS_IDLE && !bus_stop);
    c_cfg_read: cover property (st_q == BS_RD && idx_q[1:0] == SEL_CFG);
endmodule // tsp_sensor_port
`default_nettype wire

// *** verilog/tsp_pkg.sv ***
// Shared constants, types and timing for the temperature sensor port
package tsp_pkg;
    // Clock and timing figures, times in their own units
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
    localparam int unsigned CONV_TIME_MS = 26;
    localparam int unsigned CONV_MAX_MS = 35;
    localparam int unsigned CONV_CYC = CONV_TIME_MS * CYC_PER_MS;
    localparam int unsigned TIMEOUT_MS = 30;
    localparam int unsigned TIMEOUT_MAX_MS = 40;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
    // Conversion periods for rate codes 0..3 (0.25, 1, 4, 8 per second)
    localparam int unsigned RATE_MS_0 = 4000;
    localparam int unsigned RATE_MS_1 = 1000;
    localparam int unsigned RATE_MS_2 = 250;
    localparam int unsigned RATE_MS_3 = 125;
    localparam int unsigned PERIOD_CYC_0 = RATE_MS_0 * CYC_PER_MS;
    localparam int unsigned PERIOD_CYC_1 = RATE_MS_1 * CYC_PER_MS;
    localparam int unsigned PERIOD_CYC_2 = RATE_MS_2 * CYC_PER_MS;
    localparam int unsigned PERIOD_CYC_3 = RATE_MS_3 * CYC_PER_MS;
    // Register selection codes
    localparam logic [1:0] SEL_TEMP = 2'h0;
    localparam logic [1:0] SEL_CFG = 2'h1;
    localparam logic [1:0] SEL_LOW = 2'h2;
    localparam logic [1:0] SEL_HIGH = 2'h3;
    // Values after reset
    localparam logic [7:0] IDX_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h02;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic [7:0] HIGH_RESET = 8'h3c;
    localparam logic [7:0] LOW_RESET = 8'hf6;
    // Bus addresses
    localparam logic [6:0] OWN_ADDR_DEF = 7'h70;
    localparam logic [3:0] ADDR_FAMILY = 4'he;
    localparam logic [6:0] GLOBAL_ADDR_DEF = 7'h01;
    // Operating modes and bits per byte
    localparam logic [1:0] MODE_SHUT = 2'h0;
    localparam logic [1:0] MODE_ONE = 2'h1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // Configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic id;
        logic [1:0] rate;
        logic over_limit_flag;
        logic under_limit_flag;
        logic flag_latch_enable;
        logic [1:0] mode;
    } tsp_cfg_t;
    // Conversion result handed from the scheduler
    typedef struct packed {
        logic done;
        logic [7:0] value;
    } tsp_conv_t;
    // Serial state machine, Gray coded along the usual path
    typedef enum logic [2:0] {
        BS_IDLE = 3'b000,
        BS_ADDR = 3'b001,
        BS_ACK_A = 3'b011,
        BS_WR = 3'b010,
        BS_ACK_W = 3'b110,
        BS_RD = 3'b111,
        BS_MACK = 3'b101
    } tsp_bus_st_t;
    typedef enum logic {
        CV_WAIT = 1'b0,
        CV_RUN = 1'b1
    } tsp_cv_st_t;
endpackage

// *** verilog/tsp_conv_sched.sv ***
// Conversion scheduler: timing of single, periodic and shutdown modes
`timescale 1ns/1ps
`default_nettype none
module tsp_conv_sched import tsp_pkg::*; #(
    parameter int unsigned CONV_CYCLES = CONV_CYC,
    parameter int unsigned PERIOD_0 = PERIOD_CYC_0,
    parameter int unsigned PERIOD_1 = PERIOD_CYC_1,
    parameter int unsigned PERIOD_2 = PERIOD_CYC_2,
    parameter int unsigned PERIOD_3 = PERIOD_CYC_3
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [1:0] mode_in,
    input wire logic [1:0] rate_in,
    input wire logic [7:0] sample_in,
    output tsp_conv_t conv_out,
    output logic busy_out
);
    tsp_cv_st_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d;
    tsp_conv_t conv_q, conv_d;
    logic busy_q, busy_d;

    // Idle time after a conversion for the selected rate
    function automatic logic [31:0] wait_of(input logic [1:0] r);
        case (r)
            2'h0: wait_of = 32'(PERIOD_0 - CONV_CYCLES);
            2'h1: wait_of = 32'(PERIOD_1 - CONV_CYCLES);
            2'h2: wait_of = 32'(PERIOD_2 - CONV_CYCLES);
            default: wait_of = 32'(PERIOD_3 - CONV_CYCLES);
        endcase
    endfunction

    // Next state of the conversion timer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 32'h1;
        conv_d = '{done: 1'b0, value: conv_q.value};
        busy_d = busy_q;
        unique case (st_q)
            CV_RUN: begin
                if (cnt_q == 32'(CONV_CYCLES - 1)) begin
                    st_d = CV_WAIT;
                    cnt_d = 32'h0;
                    conv_d = '{done: 1'b1, value: sample_in};
                    busy_d = 1'b0;
                end
            end
            CV_WAIT: begin
                if (mode_in[1]) begin
                    if (cnt_q >= wait_of(rate_in) - 32'h1) begin
                        st_d = CV_RUN;
                        cnt_d = 32'h0;
                        busy_d = 1'b1;
                    end
                end else if (mode_in == MODE_ONE &&
                             !conv_q.done) begin
                    st_d = CV_RUN;
                    cnt_d = 32'h0;
                    busy_d = 1'b1;
                end else begin
                    cnt_d = 32'h0;
                end
            end
        endcase
    end

    // State registers; a conversion starts straight after reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_q <= CV_RUN;
            cnt_q <= 32'h0;
            conv_q <= '{done: 1'b0, value: TEMP_RESET};
            busy_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            conv_q <= conv_d;
            busy_q <= busy_d;
        end
    end

    assign conv_out = conv_q;
    assign busy_out = busy_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    a_conv_time: assert property (conv_q.done |-> $past(busy_q) &&
        $past(cnt_q) == 32'(CONV_CYCLES - 1)) else $error("bad conv length");
    a_cont_restart: assert property (st_q == CV_WAIT && mode_in[1] &&
        cnt_q == wait_of(rate_in) - 32'h1 |=> busy_q)
        else $error("periodic conversion missed");
    a_shut_idle: assert property (st_q == CV_WAIT &&
        mode_in == MODE_SHUT |=> !busy_q) else $error("ran in shutdown");
    // Mode still reads 01 in the cycle the one-shot result lands
    a_oneshot_single: assert property (st_q == CV_WAIT &&
        conv_q.done && mode_in == MODE_ONE |=> !busy_q)
        else $error("one-shot ran twice");
    c_conv_done: cover property (conv_q.done);
endmodule // tsp_conv_sched
`default_nettype wire

// *** tb/tsp_bus_master.sv ***
// Two-wire bus master model that drives clock and data for the sensor port
`timescale 1ns/1ps
`default_nettype none
module tsp_bus_master (
    input wire logic clk_sys_in,
    input wire logic sda_in,
    output var logic scl_out,
    output var logic sda_low_out
);
    // Idle bus: clock driven high, data left to its pull-up
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Wait a number of system clock falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // One bit out, data moved well after the clock falls
    task automatic put_bit(input logic b);
        tick(4);
        sda_low_out = ~b;
        tick(12);
        scl_out = 1'b1;
        tick(16);
        scl_out = 1'b0;
    endtask
    // One bit in, sampled in the middle of the high phase
    task automatic get_bit(output logic b);
        tick(4);
        sda_low_out = 1'b0;
        tick(12);
        scl_out = 1'b1;
        tick(8);
        b = sda_in;
        tick(8);
        scl_out = 1'b0;
    endtask
    // Start or repeated start: data falls while the clock is high
    task automatic start();
        tick(4);
        sda_low_out = 1'b0;
        tick(12);
        scl_out = 1'b1;
        tick(16);
        sda_low_out = 1'b1;
        tick(16);
        scl_out = 1'b0;
    endtask
    // Stop: data rises while the clock is high, then the bus idles
    task automatic stop();
        tick(4);
        sda_low_out = 1'b1;
        tick(12);
        scl_out = 1'b1;
        tick(16);
        sda_low_out = 1'b0;
        tick(16);
    endtask
    // Byte out MSB first; ack is high when the device pulled data low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic n;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(n);
        ack = ~n;
    endtask
    // Byte in MSB first, then acknowledge unless it is the last one
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(last);
    endtask
endmodule // tsp_bus_master
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the temperature sensor register port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tsp_pkg::*;
    localparam int unsigned CONV_N = 20;
    localparam int unsigned PER_N [4] = '{100, 80, 60, 40};
    logic clk_sys_in, rst_b_in, scl, m_low, sda_oe, sda_dat, busy;
    logic [7:0] sample;
    wire logic sda_w;
    int bad_count, check_count, cyc;
    // Open-drain data line with pull-up, resolved from both parties
    assign sda_w = (sda_oe ? sda_dat : 1'b1) & ~m_low;
    tsp_sensor_port #(.CONV_CYCLES(CONV_N), .TIMEOUT_CYCLES(200),
        .PERIOD_0(PER_N[0]), .PERIOD_1(PER_N[1]), .PERIOD_2(PER_N[2]),
        .PERIOD_3(PER_N[3])) u_tsp_sensor_port (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_w),
        .temp_sample_in(sample), .sda_data_out(sda_dat),
        .sda_oe_out(sda_oe), .conv_busy_out(busy));
    tsp_bus_master u_tsp_bus_master (.clk_sys_in(clk_sys_in),
        .sda_in(sda_w), .scl_out(scl), .sda_low_out(m_low));
    // 200 MHz system clock
    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end
    // Cycle ceiling cuts a hang short
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Write transfer: index byte, then an optional data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] idx, d,
                      input bit has_d);
        logic k;
        u_tsp_bus_master.start();
        u_tsp_bus_master.send_byte({a, 1'b0}, k);
        u_tsp_bus_master.send_byte(idx, k);
        if (has_d) u_tsp_bus_master.send_byte(d, k);
        u_tsp_bus_master.stop();
    endtask
    // Read transfer of one byte from the selected register
    task automatic rd(input logic [6:0] a, output logic [7:0] d,
                      output logic k);
        d = 8'h00;
        u_tsp_bus_master.start();
        u_tsp_bus_master.send_byte({a, 1'b1}, k);
        if (k === 1'b1) u_tsp_bus_master.recv_byte(1'b1, d);
        u_tsp_bus_master.stop();
    endtask
    // Select a register, read it back and compare
    task automatic rchk(input string nm, input logic [1:0] s,
                        input logic [7:0] exp);
        logic [7:0] d;
        logic k;
        wr(OWN_ADDR_DEF, {6'h00, s}, 8'h00, 1'b0);
        rd(OWN_ADDR_DEF, d, k);
        chk(nm, d, exp);
    endtask
    // Count cycles the busy output stays at one level, at most 200
    task automatic cnt(input logic lvl, output int n);
        n = 0;
        while (busy === lvl && n < 200) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask
    // Reset state: temperature selected, reset values of the config and limit registers
    task automatic t_reset();
        logic [7:0] d;
        logic k;
        rd(OWN_ADDR_DEF, d, k);
        chk("temp by default", d, 8'h19);
        rchk("config reset", SEL_CFG, CFG_RESET);
        rchk("low reset", SEL_LOW, LOW_RESET);
        rchk("high reset", SEL_HIGH, HIGH_RESET);
    endtask
    // Limits written and read back; result register ignores writes
    task automatic t_regs();
        wr(OWN_ADDR_DEF, {6'h00, SEL_LOW}, 8'h10, 1'b1);
        wr(OWN_ADDR_DEF, {6'h00, SEL_HIGH}, 8'h20, 1'b1);
        wr(OWN_ADDR_DEF, {6'h00, SEL_TEMP}, 8'h55, 1'b1);
        rchk("low limit", SEL_LOW, 8'h10);
        rchk("high limit", SEL_HIGH, 8'h20);
        rchk("temp read only", SEL_TEMP, 8'h19);
    endtask
    // Each rate code gives its period; conversion length is fixed
    task automatic t_rate();
        int n, hi, lo;
        for (int r = 0; r < 4; r++) begin
            wr(OWN_ADDR_DEF, {6'h00, SEL_CFG},
               {1'b0, 2'(r), 3'b000, 2'b10}, 1'b1);
            repeat (2) begin
                cnt(1'b1, n);
                cnt(1'b0, n);
            end
            cnt(1'b1, hi);
            cnt(1'b0, lo);
            chk("busy high", 8'(hi), 8'(CONV_N));
            chk("busy low", 8'(lo), 8'(PER_N[r] - CONV_N));
        end
    endtask
    // Limit flags follow the compare at rate 3, limits 0x10 and 0x20
    task automatic t_flags();
        sample = 8'h28;
        rchk("over flag", SEL_CFG, 8'h72);
        sample = 8'h20;
        rchk("at high limit", SEL_CFG, 8'h62);
        sample = 8'h05;
        rchk("under flag", SEL_CFG, 8'h6a);
        sample = 8'h10;
        rchk("at low limit", SEL_CFG, 8'h62);
        // Latched flag survives a return to range until a config read
        wr(OWN_ADDR_DEF, {6'h00, SEL_CFG}, 8'h66, 1'b1);
        sample = 8'h28;
        repeat (100) @(negedge clk_sys_in);
        sample = 8'h18;
        rchk("latched flag", SEL_CFG, 8'h76);
        rchk("latch cleared by read", SEL_CFG, 8'h66);
    endtask
    // Shutdown stops conversions; one-shot runs one and reads back 00
    task automatic t_oneshot();
        int n;
        sample = 8'h15;
        wr(OWN_ADDR_DEF, {6'h00, SEL_CFG}, 8'h00, 1'b1);
        cnt(1'b1, n);
        cnt(1'b0, n);
        chk("shutdown idle", 8'(n), 8'd200);
        sample = 8'h16;
        wr(OWN_ADDR_DEF, {6'h00, SEL_CFG}, 8'h01, 1'b1);
        rchk("one-shot mode", SEL_CFG, 8'h00);
        rchk("one-shot result", SEL_TEMP, 8'h16);
    endtask
    // Foreign and shared addresses, then a stall ended by the timeout
    task automatic t_bus();
        logic [7:0] d;
        logic k;
        rd(7'h71, d, k);
        chk("foreign address ack", {7'h00, k}, 8'h00);
        rd(GLOBAL_ADDR_DEF, d, k);
        chk("shared address ack", {7'h00, k}, 8'h01);
        chk("shared address data", d, 8'h16);
        u_tsp_bus_master.start();
        u_tsp_bus_master.send_byte({OWN_ADDR_DEF, 1'b1}, k);
        repeat (150) @(negedge clk_sys_in);
        chk("held before timeout", {7'h00, sda_oe}, 8'h01);
        repeat (100) @(negedge clk_sys_in);
        chk("released on timeout", {7'h00, sda_oe}, 8'h00);
        rd(OWN_ADDR_DEF, d, k);
        chk("read after timeout", d, 8'h16);
    endtask
    // Main sequence: reset for 6 cycles, then the scenarios
    initial begin
        rst_b_in = 1'b0;
        sample = 8'h19;
        bad_count = 0;
        check_count = 0;
        repeat (6) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        t_reset();
        t_regs();
        t_rate();
        t_flags();
        t_oneshot();
        t_bus();
        finish_test();
    end
endmodule // tb
`default_nettype wire
